// ===== hdl/cpmg_boot.sv
// Boot-time load of the live protection mode
`timescale 1ns/1ps
`include "cpmg_defines.svh"
module cpmg_boot
    import cpmg_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    output logic            sfl_rd_req,
    output logic [7:0]      sfl_rd_macro,
    output logic [7:0]      sfl_rd_offset,
    input  wire logic [7:0] sfl_rd_data,
    input  wire logic       sfl_rd_valid,
    output logic [7:0]      live_mode,
    output logic            boot_done
);
    cpmg_boot_s q_ff;
    cpmg_boot_s nxt_q;

    // ------------------------------------------------------------
    // Stored to live translation
    // ------------------------------------------------------------
    function automatic logic [7:0] to_live(input logic [7:0] s);
        logic [7:0] r;
        case (s)
            `CPMG_STORE_UNLOCK: r = `CPMG_MODE_UNLOCK;
            `CPMG_STORE_BLANK:  r = `CPMG_MODE_BLANK;
            `CPMG_MODE_LOCK:    r = `CPMG_MODE_LOCK;
            `CPMG_MODE_KILL:    r = `CPMG_MODE_KILL;
            default:            r = `CPMG_MODE_LOCK;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // One read after reset; the mode then stays until next reset
    // ------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        nxt_q.rd_req = 1'b0;
        case (q_ff.st)
            B_REQ: begin
                nxt_q.rd_req = 1'b1;
                nxt_q.st = B_WAIT;
            end
            B_WAIT: begin
                if (sfl_rd_valid) begin
                    nxt_q.live = to_live(sfl_rd_data);
                    nxt_q.done = 1'b1;
                    nxt_q.st = B_DONE;
                end
            end
            B_DONE: begin
                nxt_q.st = B_DONE;
            end
            default: begin
                nxt_q.st = B_REQ;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q_ff <= '{st: B_REQ, rd_req: 1'b0,
                      live: `CPMG_MODE_LOCK, done: 1'b0};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign sfl_rd_req    = q_ff.rd_req;
    assign sfl_rd_macro  = `CPMG_PROT_MACRO;
    assign sfl_rd_offset = `CPMG_PROT_OFFSET;
    assign live_mode     = q_ff.live;
    assign boot_done     = q_ff.done;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    boot_swap_zero_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (q_ff.st == B_WAIT && sfl_rd_valid && sfl_rd_data == 8'h00)
        |=> (live_mode == `CPMG_MODE_UNLOCK) && boot_done)
        else $error("stored zero did not boot unlocked");

    boot_swap_one_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (q_ff.st == B_WAIT && sfl_rd_valid && sfl_rd_data == 8'h01)
        |=> live_mode == `CPMG_MODE_BLANK)
        else $error("stored one did not boot blank");

    boot_bad_code_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (q_ff.st == B_WAIT && sfl_rd_valid &&
         !(sfl_rd_data inside {8'h00, 8'h01, 8'h02, 8'h04}))
        |=> live_mode == `CPMG_MODE_LOCK)
        else $error("undefined stored code not locked");

    boot_mode_hold_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        boot_done |=> $stable(live_mode) && boot_done)
        else $error("live mode changed after boot");
endmodule

// ===== hdl/cpmg_defines.svh
// Constants of the chip protection mode gate
//
// Summary of operation
// - Gate only debug link accesses, never firmware
// - Refused link access answered with fault acknowledge
// - Four modes: 00 blank, 01, 02, 04
// - Unlocked mode grants every resource
// - Locked mode refuses ordinary resource reads, writes
// - Locked still allows identity read, unlock command
// - Permanent lock refuses every link access
// - Stored byte: macro zero, offset 7F
// - Byte written only through row protection update
// - Stored code swaps unlocked and blank
// - Boot swaps stored 00 and 01
// - Boot copies locked, permanent lock unchanged
// - Erased zero byte boots as unlocked
// - Unlocked goes anywhere; locked only unlocked
// - Permanent lock has no exit
// - Acknowledge codes 001 ok, 010 wait, 100 fault
`ifndef CPMG_DEFINES_SVH
`define CPMG_DEFINES_SVH

// ----------------------------------------------------------------
// Live mode codes and their stored forms
// ----------------------------------------------------------------
`define CPMG_MODE_BLANK    8'h00
`define CPMG_MODE_UNLOCK   8'h01
`define CPMG_MODE_LOCK     8'h02
`define CPMG_MODE_KILL     8'h04
`define CPMG_STORE_BLANK   8'h01
`define CPMG_STORE_UNLOCK  8'h00

// ----------------------------------------------------------------
// Location of the stored protection byte
// ----------------------------------------------------------------
`define CPMG_PROT_MACRO    8'h00
`define CPMG_PROT_OFFSET   8'h7F

// ----------------------------------------------------------------
// Link acknowledge codes and packet bit counts
// ----------------------------------------------------------------
`define CPMG_ACK_OK        3'h1
`define CPMG_ACK_WAIT      3'h2
`define CPMG_ACK_FAULT     3'h4
`define CPMG_HDR_LAST      6'h07
`define CPMG_ACK_LAST      6'h03
`define CPMG_DATA_LAST     6'h20
`define CPMG_RD_END        6'h21

`endif

// ===== hdl/cpmg_gate.sv
// Serial debug link engine gated by the chip protection mode
`timescale 1ns/1ps
`include "cpmg_defines.svh"
module cpmg_gate
    import cpmg_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        swd_clk_pin,
    input  wire logic        swdio_in,
    output logic             swdio_out,
    output logic             swdio_oe,
    output logic             acc_req,
    output cpmg_req_s        acc_info,
    input  wire cpmg_cls_e   acc_cls,
    input  wire logic [31:0] acc_rdata,
    input  wire logic        acc_rvalid,
    output logic             prot_prog_req,
    output logic [7:0]       prot_prog_byte,
    output logic             sfl_rd_req,
    output logic [7:0]       sfl_rd_macro,
    output logic [7:0]       sfl_rd_offset,
    input  wire logic [7:0]  sfl_rd_data,
    input  wire logic        sfl_rd_valid,
    output logic [7:0]       live_mode,
    output logic             boot_done
);
    cpmg_gate_s  q_ff;
    cpmg_gate_s  nxt_q;
    logic [1:0]  pins_s;
    logic        s_clk;
    logic        s_dio;
    logic        rise;
    logic        grant;
    logic [6:0]  hdr;
    logic [32:0] wfull;

    // ------------------------------------------------------------
    // Pin synchroniser and boot loader
    // ------------------------------------------------------------
    cpmg_sync #(.W(2)) u_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .din      ({swd_clk_pin, swdio_in}),
        .dout     (pins_s)
    );

    cpmg_boot u_boot (
        .core_clk      (core_clk),
        .resetn        (resetn),
        .sfl_rd_req    (sfl_rd_req),
        .sfl_rd_macro  (sfl_rd_macro),
        .sfl_rd_offset (sfl_rd_offset),
        .sfl_rd_data   (sfl_rd_data),
        .sfl_rd_valid  (sfl_rd_valid),
        .live_mode     (live_mode),
        .boot_done     (boot_done)
    );

    assign s_clk = pins_s[1];
    assign s_dio = pins_s[0];
    assign rise  = s_clk && !q_ff.sclk_q;

    // ------------------------------------------------------------
    // Access policy per live mode
    // ------------------------------------------------------------
    // Firmware paths never pass through here, so only link
    // accesses can be refused.
    function automatic logic allows(input logic [7:0] m,
                                    input cpmg_cls_e  c);
        logic r;
        case (m)
            `CPMG_MODE_BLANK,
            `CPMG_MODE_UNLOCK: r = 1'b1;
            `CPMG_MODE_LOCK:   r = (c == CLS_ID) ||
                                   (c == CLS_MODE);
            default:           r = 1'b0;
        endcase
        return r;
    endfunction

    // Blank is not blocked from blank or unlocked, only discouraged for the host
    function automatic logic legal_move(input logic [7:0] cur,
                                        input logic [7:0] req);
        logic r;
        case (cur)
            `CPMG_MODE_BLANK,
            `CPMG_MODE_UNLOCK: r = req inside {`CPMG_MODE_BLANK,
                                   `CPMG_MODE_UNLOCK, `CPMG_MODE_LOCK,
                                   `CPMG_MODE_KILL};
            `CPMG_MODE_LOCK:   r = (req == `CPMG_MODE_UNLOCK);
            default:           r = 1'b0;
        endcase
        return r;
    endfunction

    // Stored form swaps the two lowest modes
    function automatic logic [7:0] to_store(input logic [7:0] m);
        logic [7:0] r;
        case (m)
            `CPMG_MODE_UNLOCK: r = `CPMG_STORE_UNLOCK;
            `CPMG_MODE_BLANK:  r = `CPMG_STORE_BLANK;
            default:           r = m;
        endcase
        return r;
    endfunction

    assign grant = boot_done && allows(live_mode, acc_cls);
    assign hdr   = {s_dio, q_ff.shf[32:27]};
    assign wfull = {s_dio, q_ff.shf[32:1]};

    // ------------------------------------------------------------
    // Link engine, stepped on each sampled rising link clock edge
    // ------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        nxt_q.sclk_q = s_clk;
        nxt_q.acc_req = 1'b0;
        nxt_q.prog_req = 1'b0;
        if (acc_rvalid) begin
            nxt_q.rbuf = acc_rdata;
        end
        if (rise) begin
            case (q_ff.st)
                ST_IDLE: begin
                    if (s_dio) begin
                        nxt_q.st = ST_HDR;
                        nxt_q.cnt = 6'h01;
                        nxt_q.shf = '0;
                    end
                end
                ST_HDR: begin
                    nxt_q.shf = {s_dio, q_ff.shf[32:1]};
                    nxt_q.cnt = q_ff.cnt + 6'h01;
                    if (q_ff.cnt == `CPMG_HDR_LAST) begin
                        // Bad parity, stop or park: no answer at all
                        if ((^hdr[3:0]) == hdr[4] && !hdr[5] && hdr[6]) begin
                            nxt_q.req.apndp = hdr[0];
                            nxt_q.req.rnw   = hdr[1];
                            nxt_q.req.addr  = hdr[3:2];
                            nxt_q.st = ST_TRN;
                        end else begin
                            nxt_q.st = ST_IDLE;
                        end
                    end
                end
                ST_TRN: begin
                    nxt_q.cls = acc_cls;
                    if (q_ff.wpar_err) begin
                        nxt_q.ack = `CPMG_ACK_FAULT;
                        nxt_q.wpar_err = 1'b0;
                    end else if (grant) begin
                        nxt_q.ack = `CPMG_ACK_OK;
                        nxt_q.acc_req = q_ff.req.rnw;
                    end else begin
                        nxt_q.ack = `CPMG_ACK_FAULT;
                    end
                    nxt_q.dio_o = nxt_q.ack[0];
                    nxt_q.dio_oe = 1'b1;
                    nxt_q.cnt = 6'h01;
                    nxt_q.st = ST_ACK;
                end
                ST_ACK: begin
                    nxt_q.cnt = q_ff.cnt + 6'h01;
                    if (q_ff.cnt != `CPMG_ACK_LAST) begin
                        nxt_q.dio_o = q_ff.ack[q_ff.cnt[1:0]];
                    end else if (q_ff.ack != `CPMG_ACK_OK) begin
                        nxt_q.dio_oe = 1'b0;
                        nxt_q.st = ST_IDLE;
                    end else if (q_ff.req.rnw) begin
                        nxt_q.dio_o = q_ff.rbuf[0];
                        nxt_q.cnt = 6'h01;
                        nxt_q.st = ST_RDATA;
                    end else begin
                        nxt_q.dio_oe = 1'b0;
                        nxt_q.cnt = 6'h00;
                        nxt_q.st = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    nxt_q.cnt = q_ff.cnt + 6'h01;
                    if (q_ff.cnt < `CPMG_DATA_LAST) begin
                        nxt_q.dio_o = q_ff.rbuf[q_ff.cnt[4:0]];
                    end else if (q_ff.cnt == `CPMG_DATA_LAST) begin
                        nxt_q.dio_o = ^q_ff.rbuf;
                    end else begin
                        nxt_q.dio_oe = 1'b0;
                        nxt_q.st = ST_IDLE;
                    end
                end
                ST_WDATA: begin
                    nxt_q.shf = wfull;
                    nxt_q.cnt = q_ff.cnt + 6'h01;
                    if (q_ff.cnt == `CPMG_RD_END) begin
                        nxt_q.st = ST_IDLE;
                        if (^wfull) begin
                            // Reported as fault in the next packet
                            nxt_q.wpar_err = 1'b1;
                        end else if (q_ff.cls == CLS_MODE) begin
                            // Goes to flash with the row update only
                            if (legal_move(live_mode, wfull[7:0])) begin
                                nxt_q.prog_req = 1'b1;
                                nxt_q.prog_byte = to_store(wfull[7:0]);
                            end
                        end else begin
                            nxt_q.req.wdata = wfull[31:0];
                            nxt_q.acc_req = 1'b1;
                        end
                    end
                end
                default: begin
                    nxt_q.dio_oe = 1'b0;
                    nxt_q.st = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // The live mode is only read here, so a new stored byte waits
    // for the next reset before it changes any decision.
    assign swdio_out      = q_ff.dio_o;
    assign swdio_oe       = q_ff.dio_oe;
    assign acc_req        = q_ff.acc_req;
    assign acc_info       = q_ff.req;
    assign prot_prog_req  = q_ff.prog_req;
    assign prot_prog_byte = q_ff.prog_byte;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    kill_all_fault_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (rise && q_ff.st == ST_TRN && live_mode == `CPMG_MODE_KILL)
        |=> q_ff.ack == `CPMG_ACK_FAULT && !q_ff.acc_req)
        else $error("permanent lock granted a link access");

    lock_res_fault_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (rise && q_ff.st == ST_TRN && live_mode == `CPMG_MODE_LOCK &&
         acc_cls == CLS_RES)
        |=> q_ff.ack == `CPMG_ACK_FAULT)
        else $error("locked mode granted a resource access");

    lock_id_ok_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (rise && q_ff.st == ST_TRN && boot_done && !q_ff.wpar_err &&
         live_mode == `CPMG_MODE_LOCK && acc_cls != CLS_RES)
        |=> q_ff.ack == `CPMG_ACK_OK)
        else $error("locked mode refused identity or unlock");

    unlock_ok_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (rise && q_ff.st == ST_TRN && boot_done && !q_ff.wpar_err &&
         live_mode == `CPMG_MODE_UNLOCK)
        |=> q_ff.ack == `CPMG_ACK_OK ##1 q_ff.dio_oe)
        else $error("unlocked mode refused an access");

    fault_no_data_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (rise && q_ff.st == ST_ACK && q_ff.cnt == `CPMG_ACK_LAST &&
         q_ff.ack == `CPMG_ACK_FAULT)
        |=> (q_ff.st == ST_IDLE && !q_ff.dio_oe)[*2])
        else $error("refused packet entered a data phase");

    ack_code_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        q_ff.st == ST_ACK
        |-> q_ff.dio_oe &&
            (q_ff.ack == `CPMG_ACK_OK || q_ff.ack == `CPMG_ACK_FAULT))
        else $error("acknowledge not driven with a valid code");

    wpar_fault_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (rise && q_ff.st == ST_TRN && q_ff.wpar_err)
        |=> q_ff.ack == `CPMG_ACK_FAULT && !q_ff.wpar_err && !q_ff.acc_req)
        else $error("write parity error not reported as fault");

    kill_no_exit_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        q_ff.prog_req |-> $past(live_mode) != `CPMG_MODE_KILL)
        else $error("mode change issued from permanent lock");

    lock_to_unlock_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (q_ff.prog_req && live_mode == `CPMG_MODE_LOCK)
        |-> q_ff.prog_byte == `CPMG_STORE_UNLOCK)
        else $error("locked mode moved somewhere but unlocked");

    rd_only_granted_a: assert property (
        @(posedge core_clk) disable iff (!resetn)
        (q_ff.acc_req && q_ff.req.rnw) |-> allows(live_mode, q_ff.cls))
        else $error("read issued to a refused resource");
endmodule

// ===== hdl/cpmg_pkg.sv
// Types of the chip protection mode gate
package cpmg_pkg;

    // ------------------------------------------------------------
    // Link engine and boot states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_HDR, ST_TRN, ST_ACK, ST_RDATA, ST_WDATA
    } cpmg_link_e;

    typedef enum logic [1:0] {
        B_REQ, B_WAIT, B_DONE
    } cpmg_boot_e;

    // Target class of the pending link access, named by the decoder
    typedef enum logic [1:0] {
        CLS_RES, CLS_ID, CLS_MODE
    } cpmg_cls_e;

    // ------------------------------------------------------------
    // Carriers and module state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        apndp;
        logic        rnw;
        logic [1:0]  addr;
        logic [31:0] wdata;
    } cpmg_req_s;

    typedef struct packed {
        cpmg_link_e  st;
        logic [5:0]  cnt;
        logic [32:0] shf;
        cpmg_req_s   req;
        cpmg_cls_e   cls;
        logic        sclk_q;
        logic        dio_o;
        logic        dio_oe;
        logic [2:0]  ack;
        logic        wpar_err;
        logic        acc_req;
        logic [31:0] rbuf;
        logic        prog_req;
        logic [7:0]  prog_byte;
    } cpmg_gate_s;

    typedef struct packed {
        cpmg_boot_e  st;
        logic        rd_req;
        logic [7:0]  live;
        logic        done;
    } cpmg_boot_s;

endpackage

// ===== hdl/cpmg_sync.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module cpmg_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [1:0][W-1:0] q_ff;
    logic [1:0][W-1:0] nxt_q;

    // First stage feeds only the second stage
    always_comb begin
        nxt_q = {q_ff[0], din};
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign dout = q_ff[1];
endmodule

// ===== tb/cpmg_host_model.sv
// Serial debug host model: link clock, data pin and packet task
`timescale 1ns/1ps
module cpmg_host_model (
    output logic      swd_clk_pin,
    output logic      swdio_in,
    input  wire logic swdio_out,
    input  wire logic swdio_oe
);
    logic drv_en = 1'b1;
    logic drv    = 1'b0;
    logic flip   = 1'b0;

    // Link clock stands still between frames
    initial swd_clk_pin = 1'b0;
    // Released wire changes on each rising link clock edge so a stale value cannot pass
    always @(posedge swd_clk_pin) flip <= ~flip;
    assign swdio_in = swdio_oe ? swdio_out : (drv_en ? drv : flip);

    task automatic tick();
        #62.5 swd_clk_pin = 1'b1;
        #62.5 swd_clk_pin = 1'b0;
    endtask

    task automatic put(input logic b);
        drv_en = 1'b1;
        drv = b;
        tick();
    endtask

    task automatic get(output logic b);
        drv_en = 1'b0;
        #62.5 swd_clk_pin = 1'b1;
        #62.5 b = swdio_in;
        swd_clk_pin = 1'b0;
    endtask

    task automatic packet(input logic rnw, input logic [1:0] a,
                          input logic [31:0] wd, input logic bad_wp,
                          output logic [2:0] ack, output logic [31:0] rd,
                          output logic pok);
        logic p;
        rd = 32'h0;
        pok = 1'b1;
        put(1'b1);
        put(1'b1);
        put(rnw);
        put(a[0]);
        put(a[1]);
        put(^{1'b1, rnw, a});
        put(1'b0);
        put(1'b1);
        for (int i = 0; i < 3; i++) get(ack[i]);
        if (ack == 3'h1 && rnw) begin
            for (int i = 0; i < 32; i++) get(rd[i]);
            get(p);
            pok = (p === ^rd);
            tick();
        end else if (ack == 3'h1) begin
            get(p);
            get(p);
            for (int i = 0; i < 32; i++) put(wd[i]);
            put(^wd ^ bad_wp);
        end else begin
            get(p);
        end
        drv_en = 1'b1;
        drv = 1'b0;
    endtask
endmodule

// ===== tb/tb_top.sv
// Self-checking bench of the chip protection mode gate
`timescale 1ns/1ps
module tb_top
    import cpmg_pkg::*;
;
    logic core_clk = 1'b0, resetn = 1'b0;
    logic sfl_rd_valid = 1'b0, acc_rvalid = 1'b0;
    logic [7:0] sfl_rd_data = 8'h00;
    logic [31:0] acc_rdata = 32'h0;
    cpmg_cls_e acc_cls = CLS_RES;
    wire swd_clk_pin, swdio_in, swdio_out, swdio_oe, acc_req;
    wire prot_prog_req, sfl_rd_req, boot_done;
    wire [7:0] prot_prog_byte, sfl_rd_macro, sfl_rd_offset, live_mode;
    cpmg_req_s acc_info;
    int err_total = 0, total_checks = 0, prog_n = 0, wr_n = 0, rdly = 0;
    logic [31:0] wr_d;
    logic [3:0] acc_hdr;
    logic [7:0] prog_b;

    initial forever #4 core_clk = ~core_clk;

    cpmg_gate u_dut (.core_clk, .resetn, .swd_clk_pin, .swdio_in,
        .swdio_out, .swdio_oe, .acc_req, .acc_info, .acc_cls, .acc_rdata,
        .acc_rvalid, .prot_prog_req, .prot_prog_byte, .sfl_rd_req,
        .sfl_rd_macro, .sfl_rd_offset, .sfl_rd_data, .sfl_rd_valid,
        .live_mode, .boot_done);
    cpmg_host_model u_host (.swd_clk_pin, .swdio_in, .swdio_out, .swdio_oe);

    // Resource side answers reads after a random delay
    always @(negedge core_clk) begin
        acc_rvalid <= (rdly == 1);
        if (prot_prog_req) begin prog_n++; prog_b = prot_prog_byte; end
        if (acc_req && !acc_info.rnw) begin wr_n++; wr_d = acc_info.wdata; end
        if (acc_req) acc_hdr = {acc_info.apndp, acc_info.rnw, acc_info.addr};
        if (acc_req && acc_info.rnw) rdly <= $urandom_range(1, 20);
        else if (rdly != 0) rdly <= rdly - 1;
    end

    function automatic logic [7:0] boot_of(input logic [7:0] s);
        case (s)
            8'h00: return 8'h01;
            8'h01: return 8'h00;
            8'h02, 8'h04: return s;
            default: return 8'h02;
        endcase
    endfunction

    function automatic logic [2:0] ack_of(input logic [7:0] m, cpmg_cls_e c);
        if (m == 8'h04 || (m == 8'h02 && c == CLS_RES)) return 3'h4;
        return 3'h1;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic boot(input logic [7:0] s);
        int n;
        resetn = 1'b0;
        repeat (5) @(negedge core_clk);
        chk(live_mode, 8'h02);
        resetn = 1'b1;
        n = 0;
        while (sfl_rd_req !== 1'b1 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        chk({sfl_rd_req, sfl_rd_macro, sfl_rd_offset}, 17'h1007F);
        repeat ($urandom_range(1, 6)) @(negedge core_clk);
        sfl_rd_data = s;
        sfl_rd_valid = 1'b1;
        @(negedge core_clk);
        sfl_rd_valid = 1'b0;
        @(negedge core_clk);
        chk(boot_done, 1'b1);
        chk(live_mode, boot_of(s));
    endtask

    task automatic pkt(input logic rnw, input cpmg_cls_e c,
                       input logic [31:0] wd, input logic bad_wp,
                       output logic [2:0] ack, output logic [31:0] rd);
        logic pk;
        logic [1:0] a;
        a = 2'($urandom_range(0, 3));
        acc_cls = c;
        acc_hdr = 4'h0;
        u_host.packet(rnw, a, wd, bad_wp, ack, rd, pk);
        repeat (12) @(negedge core_clk);
        if (ack == 3'h1 && rnw) chk(pk, 1'b1);
        if (ack == 3'h1 && (rnw || (c == CLS_RES && !bad_wp)))
            chk(acc_hdr, {1'b1, rnw, a});
    endtask

    initial begin
        #400_000;
        err_total++;
        final_report();
    end

    // ----------------------------------------------------------------
    // Boot each stored code, then probe access and mode moves
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] st [5];
        logic [7:0] m, nm;
        logic [2:0] ack;
        logic [31:0] rd, v;
        logic legal;
        void'($urandom(51));
        st = '{8'h00, 8'h01, 8'h02, 8'h04, 8'($urandom_range(8, 255))};
        for (int t = 0; t < 5; t++) begin
            boot(st[t]);
            m = boot_of(st[t]);
            for (int c = 0; c < 3; c++) begin
                v = $urandom;
                acc_rdata = v;
                pkt(1'b1, cpmg_cls_e'(c), 32'h0, 1'b0, ack, rd);
                chk(ack, ack_of(m, cpmg_cls_e'(c)));
                if (ack == 3'h1) chk(rd, v);
            end
            v = $urandom;
            wr_n = 0;
            pkt(1'b0, CLS_RES, v, 1'b0, ack, rd);
            chk(ack, ack_of(m, CLS_RES));
            chk(wr_n, (ack == 3'h1) ? 1 : 0);
            if (ack == 3'h1) chk(wr_d, v);
            // Blank is never requested, it would strip the trim
            for (int k = 0; k < 3; k++) begin
                nm = 8'h01 << k;
                prog_n = 0;
                pkt(1'b0, CLS_MODE, {24'h0, nm}, 1'b0, ack, rd);
                chk(ack, ack_of(m, CLS_MODE));
                legal = (m != 8'h04) && (m != 8'h02 || nm == 8'h01);
                chk(prog_n, legal);
                if (legal) chk(prog_b, nm == 8'h01 ? 8'h00 : nm);
                chk(live_mode, m);
            end
            if (m == 8'h01) begin
                pkt(1'b0, CLS_RES, $urandom, 1'b1, ack, rd);
                pkt(1'b1, CLS_ID, 32'h0, 1'b0, ack, rd);
                chk(ack, 3'h4);
                pkt(1'b1, CLS_ID, 32'h0, 1'b0, ack, rd);
                chk(ack, 3'h1);
            end
            $display("test %0d done, live mode %h", t, m);
        end
        final_report();
    end
endmodule
